// ===== dv/energy_accum_mode_config_tb.sv
`timescale 1ns/1ps
`include "energy_accum_map.svh"
module energy_accum_mode_config_tb import energy_accum_pkg::*;;
	logic               mclk, rst, psel, penable, pwrite, pready, pslverr, rerr;
	logic               power_valid, fault_mode, tamper_prefers_b, contrib_valid, irq;
	logic               energy_pulse_output, energy_pulse_negative, current_uses_b;
	logic               reactive_pulse_output, reactive_pulse_negative;
	logic               voltage_input_ground, current_input_ground;
	logic [11:0]        paddr;
	logic [31:0]        pwdata, prdata, rdata;
	logic [3:0]         pstrb;
	logic [2:0]         voltage_gain_shift, current_gain_shift;
	logic [1:0]         noload_threshold_sel;
	logic signed [23:0] active_power, reactive_power, active_contrib, reactive_contrib;
	logic [15:0]        s;
	logic               b;
	reg_byte_t          m;
	int                 errors, samples_checked, v;
	logic [9:0]         ix [7] = '{`IDX_ACC_MODE, `IDX_GAIN, `IDX_CAL_SEL, `IDX_NOLOAD,
		`IDX_IRQ_STAT, `IDX_IRQ_EN, `IDX_IRQ_CLR};

	energy_accum_mode_config DUT (.mclk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
		.pstrb, .pready, .prdata, .pslverr, .active_power, .reactive_power, .power_valid,
		.energy_pulse_output, .energy_pulse_negative, .reactive_pulse_output,
		.reactive_pulse_negative, .fault_mode, .tamper_prefers_b, .active_contrib,
		.reactive_contrib, .contrib_valid, .voltage_gain_shift, .current_gain_shift,
		.current_uses_b, .voltage_input_ground, .current_input_ground,
		.noload_threshold_sel, .irq);

	always #25 mclk = ~mclk;

	function automatic logic [15:0] nx(logic [15:0] x);
		return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
	endfunction

	// expected terms; absolute wins over the other modes
	function automatic int ea(int a);
		if (m[0]) return a < 0 ? -a : a;
		if (m[1]) return a < 0 ? 0 : a;
		return a;
	endfunction
	function automatic int er(int a, int r);
		if (m[3]) return r < 0 ? -r : r;
		if (m[2] && a < 0) return -r;
		return r;
	endfunction

	task automatic chk_reg(input logic [31:0] g, input logic [31:0] e);
		samples_checked++;
		if (g !== e)
		begin
			errors++;
			$display("MISMATCH %0t reg got %h exp %h", $time, g, e);
		end
	endtask
	task automatic chk_smp(input logic signed [23:0] g, input int e);
		samples_checked++;
		if (g !== e[23:0])
		begin
			errors++;
			$display("MISMATCH %0t term got %0d exp %0d", $time, g, e);
		end
	endtask

	// one transfer; request held until pready is seen high
	task automatic apb(input logic w, input logic [9:0] i, input reg_byte_t d);
		@(posedge mclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {i, 2'b00};
		pwdata <= {24'h000000, d};
		@(posedge mclk);
		penable <= 1'b1;
		// no assumed answer time; only the watchdog ends a stuck wait
		do
		begin
			@(posedge mclk);
		end
		while (pready !== 1'b1);
		rdata = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [9:0] i, input reg_byte_t d);
		apb(1'b1, i, d);
	endtask
	task automatic rd(input logic [9:0] i, input logic [31:0] e);
		apb(1'b0, i, 8'h00);
		chk_reg(rdata, e);
	endtask
	task automatic wa(input reg_byte_t d);
		m = d;
		wr(`IDX_ACC_MODE, d);
	endtask

	// one filtered sample, result looked at one cycle on
	task automatic smp(input int a, input int r);
		@(posedge mclk);
		active_power <= 24'(a);
		reactive_power <= 24'(r);
		power_valid <= 1'b1;
		@(posedge mclk);
		power_valid <= 1'b0;
		@(negedge mclk);
		chk_reg({31'h0, contrib_valid}, 32'h1);
		chk_smp(active_contrib, ea(a));
		chk_smp(reactive_contrib, er(a, r));
	endtask
	task automatic pulse(input logic n);
		@(posedge mclk);
		{energy_pulse_output, reactive_pulse_output} <= 2'b11;
		{energy_pulse_negative, reactive_pulse_negative} <= {n, n};
		@(posedge mclk);
		{energy_pulse_output, reactive_pulse_output} <= 2'b00;
	endtask

	task automatic final_report;
		$display("errors %0d samples_checked %0d", errors, samples_checked);
		if (errors == 0 && samples_checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// long stall guard, far beyond the several hundred cycles needed
	initial
	begin
		#400000;
		errors++;
		final_report();
	end

	initial
	begin
		{mclk, psel, penable, pwrite, power_valid, fault_mode, tamper_prefers_b} = '0;
		{energy_pulse_output, energy_pulse_negative} = '0;
		{reactive_pulse_output, reactive_pulse_negative} = '0;
		{paddr, pwdata, active_power, reactive_power} = '0;
		pstrb = 4'hF;
		s = 16'hB692;
		rst = 1'b1;
		repeat (12) @(posedge mclk);
		rst <= 1'b0;
		foreach (ix[k])
			rd(ix[k], 32'h0);
		$display("test reset done");
		// masks, dropped strobe, unmapped place
		wa(8'hFF);
		rd(`IDX_ACC_MODE, 32'h7F);
		wr(`IDX_GAIN, 8'hFF);
		rd(`IDX_GAIN, 32'hEF);
		pstrb <= 4'hE;
		wr(`IDX_GAIN, 8'h00);
		pstrb <= 4'hF;
		rd(`IDX_GAIN, 32'hEF);
		wr(`IDX_CAL_SEL, 8'hFF);
		rd(`IDX_CAL_SEL, 32'h3C);
		apb(1'b0, 10'h3FF, 8'h00);
		chk_reg({rerr, rdata[30:0]}, 32'h80000000);
		for (int k = 0; k < 4; k++)
		begin
			wr(`IDX_NOLOAD, 8'(k));
			repeat (2) @(negedge mclk);
			chk_reg(32'(noload_threshold_sel), k);
		end
		$display("test access done");
		for (int g = 0; g < 8; g++)
		begin
			wr(`IDX_GAIN, 8'(g * 33));
			repeat (2) @(negedge mclk);
			chk_reg(32'(voltage_gain_shift), g > 4 ? 4 : g);
			chk_reg(32'(current_gain_shift), g > 4 ? 4 : g);
		end
		$display("test gain done");
		for (int c = 0; c < 16; c++)
		begin
			@(posedge mclk);
			tamper_prefers_b <= c[0];
			wr(`IDX_CAL_SEL, 8'(c * 4));
			repeat (2) @(negedge mclk);
			b = (c[3] != c[2]) ? c[3] : c[0];
			chk_reg(32'({voltage_input_ground, current_input_ground}), c[1:0]);
			chk_reg(32'(current_uses_b), 32'(b));
			rd(`IDX_ACC_MODE, {24'h0, b, m[6:0]});
		end
		$display("test channel done");
		for (int k = 0; k < 64; k++)
		begin
			if (k % 4 == 0)
				wa(8'(k / 4));
			s = nx(s);
			v = $signed(s[11:0]) | 1;
			s = nx(s);
			smp(v, $signed(s[11:0]) | 1);
		end
		$display("test accumulate done");
		// edge selects both ways; irq enabled on one pass, masked on the other
		for (int e = 0; e < 2; e++)
		begin
			v = e ? -7 : 7;
			wr(`IDX_IRQ_EN, e ? 8'h38 : 8'h00);
			wa(e ? 8'h70 : 8'h00);
			fault_mode <= e[0];
			smp(v, v);
			wr(`IDX_IRQ_CLR, 8'hFF);
			fault_mode <= ~e[0];
			smp(-v, -v);
			rd(`IDX_IRQ_STAT, 32'h38);
			chk_reg(32'(irq), e);
			wr(`IDX_IRQ_CLR, 8'hFF);
			repeat (2) @(negedge mclk);
			chk_reg(32'(irq), 32'h0);
			rd(`IDX_IRQ_STAT, 32'h0);
		end
		// per-pulse detection ignores filtered samples
		wr(`IDX_GAIN, 8'h08);
		wa(8'h00);
		smp(5, 5);
		smp(-5, -5);
		rd(`IDX_IRQ_STAT, 32'h0);
		pulse(1'b0);
		pulse(1'b1);
		repeat (2) @(negedge mclk);
		rd(`IDX_IRQ_STAT, 32'h18);
		$display("test interrupt done");
		final_report();
	end
endmodule

// ===== dv/energy_accum_properties.sv
`timescale 1ns/1ps
`include "energy_accum_map.svh"
module energy_accum_props
	import energy_accum_pkg::*;
#(
	parameter int ADDR_WIDTH  = 12,
	parameter int POWER_WIDTH = 24
)
(
	input wire logic                          mclk,
	input wire logic                          rst,
	input wire logic                          psel,
	input wire logic                          penable,
	input wire logic                          pwrite,
	input wire logic [ADDR_WIDTH-1:0]         paddr,
	input wire logic [31:0]                   pwdata,
	input wire logic [3:0]                    pstrb,
	input wire logic                          pready,
	input wire logic signed [POWER_WIDTH-1:0] active_power,
	input wire logic signed [POWER_WIDTH-1:0] reactive_power,
	input wire logic                          contrib_valid,
	input wire logic signed [POWER_WIDTH-1:0] active_contrib,
	input wire logic signed [POWER_WIDTH-1:0] reactive_contrib,
	input wire logic [2:0]                    voltage_gain_shift,
	input wire logic [2:0]                    current_gain_shift,
	input wire logic                          current_uses_b,
	input wire logic                          voltage_input_ground,
	input wire logic                          current_input_ground
);
	reg_byte_t  acc;
	reg_byte_t  gain;
	reg_byte_t  cal;
	logic [9:0] idx;
	logic       wr;

	// shadows follow completed writes only, so a dropped strobe leaves them alone
	assign idx = paddr[ADDR_WIDTH-1:2];
	assign wr = psel && penable && pready && pwrite && pstrb[0];
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			acc <= '0;
			gain <= '0;
			cal <= '0;
		end
		else if (wr)
		begin
			if (idx == `IDX_ACC_MODE) acc <= pwdata[7:0];
			if (idx == `IDX_GAIN) gain <= pwdata[7:0];
			if (idx == `IDX_CAL_SEL) cal <= pwdata[7:0];
		end
	end

	function automatic logic signed [POWER_WIDTH-1:0] mag(logic signed [POWER_WIDTH-1:0] x);
		return x < 0 ? -x : x;
	endfunction

	default clocking dc @(posedge mclk);
	endclocking
	default disable iff (rst);

	chk_abs_active: assert property (
		contrib_valid && $past(acc[0]) |-> active_contrib == mag($past(active_power)))
		else $error("active magnitude wrong");
	chk_pos_only: assert property (
		contrib_valid && $past(acc[1:0]) == 2'b10 |->
		active_contrib == ($past(active_power) < 0 ? '0 : $past(active_power)))
		else $error("positive only wrong");
	chk_abs_reactive: assert property (
		contrib_valid && $past(acc[3]) |-> reactive_contrib == mag($past(reactive_power)))
		else $error("reactive magnitude wrong");
	chk_reactive_flip: assert property (
		contrib_valid && $past(acc[3:2]) == 2'b01 |-> reactive_contrib ==
		($past(active_power) < 0 ? -$past(reactive_power) : $past(reactive_power)))
		else $error("reactive flip wrong");
	chk_volt_gain: assert property (
		$stable(gain) |-> voltage_gain_shift == (gain[7:5] > 3'h4 ? 3'h4 : gain[7:5]))
		else $error("voltage gain wrong");
	chk_curr_gain: assert property (
		$stable(gain) |-> current_gain_shift == (gain[2:0] > 3'h4 ? 3'h4 : gain[2:0]))
		else $error("current gain wrong");
	chk_ground_map: assert property (
		$stable(cal) |-> {voltage_input_ground, current_input_ground} == cal[3:2])
		else $error("ground map wrong");
	chk_chan_force: assert property (
		$stable(cal) && cal[5] != cal[4] |-> current_uses_b == cal[5])
		else $error("forced channel wrong");
endmodule

bind energy_accum_mode_config energy_accum_props #(
	.ADDR_WIDTH(ADDR_WIDTH),
	.POWER_WIDTH(POWER_WIDTH)
) props (.mclk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .pready,
	.active_power, .reactive_power, .contrib_valid, .active_contrib, .reactive_contrib,
	.voltage_gain_shift, .current_gain_shift, .current_uses_b, .voltage_input_ground,
	.current_input_ground);

// ===== hdl/energy_accum_map.svh
`ifndef ENERGY_ACCUM_MAP_SVH
`define ENERGY_ACCUM_MAP_SVH

// register indices; byte address is four times the index
`define IDX_ACC_MODE   10'h00F
`define IDX_GAIN       10'h01B
`define IDX_CAL_SEL    10'h03D
`define IDX_NOLOAD     10'h040
`define IDX_IRQ_STAT   10'h041
`define IDX_IRQ_EN     10'h042
`define IDX_IRQ_CLR    10'h043

// accumulation mode fields
`define ACC_TAMPER_B   7
`define ACC_FAULT_EDGE 6
`define ACC_RSIGN_EDGE 5
`define ACC_ASIGN_EDGE 4
`define ACC_R_ABS      3
`define ACC_R_BY_ACT   2
`define ACC_A_POS      1
`define ACC_A_ABS      0
`define ACC_WR_MASK    8'h7F

// gain fields
`define GAIN_V_HI      7
`define GAIN_V_LO      5
`define GAIN_SIGN_PT   3
`define GAIN_I_HI      2
`define GAIN_I_LO      0
`define GAIN_WR_MASK   8'hEF
`define GAIN_MAX_SHIFT 3'h4

// calibration input select fields
`define CAL_SEL_HI     5
`define CAL_SEL_LO     4
`define CAL_V_GND      3
`define CAL_I_GND      2
`define CAL_WR_MASK    8'h3C

// no-load threshold select field
`define NOLOAD_WR_MASK 8'h03

// interrupt status layout
`define IRQ_ASIGN      3
`define IRQ_RSIGN      4
`define IRQ_FAULT      5
`define IRQ_MASK       8'h38

`define RESET_BYTE     8'h00

`endif

// ===== hdl/energy_accum_mode_config.sv
// Summary of operation
// [R1] bit 7 reports tamper current channel
// [R2] bit 6 picks fault entry or exit
// [R3] bit 5 picks reactive sign edge
// [R4] bit 4 picks active sign edge
// [R5] bit 3 accumulates absolute reactive power
// [R6] bit 2 flips reactive by active sign
// [R7] bit 1 keeps only positive active power
// [R8] bit 0 accumulates absolute active power
// [R9] bits 7-5 set voltage gain 1..16
// [R10] bits 2-0 set current gain 1..16
// [R11] gain bit 3 picks sign detect point
// [R12] select field forces input A or B
// [R13] calibration bit 3 grounds voltage input
// [R14] calibration bit 2 grounds current inputs
// [R15] software keeps calibration bits 7-6 zero
// [R16] two-bit field sets no-load threshold
// [R17] active sign event sets status bit 3
// [R18] reserved bits ignore writes, read zero
//
// Implementation choice: the APB register port.
`timescale 1ns/1ps
`include "energy_accum_map.svh"

module energy_accum_mode_config
	import energy_accum_pkg::*;
#(
	parameter int ADDR_WIDTH  = 12,
	parameter int POWER_WIDTH = 24
)
(
	input  wire logic                          mclk,
	input  wire logic                          rst,
	input  wire logic                          psel,
	input  wire logic                          penable,
	input  wire logic                          pwrite,
	input  wire logic [ADDR_WIDTH-1:0]         paddr,
	input  wire logic [31:0]                   pwdata,
	input  wire logic [3:0]                    pstrb,
	output logic                               pready,
	output logic [31:0]                        prdata,
	output logic                               pslverr,
	input  wire logic signed [POWER_WIDTH-1:0] active_power,
	input  wire logic signed [POWER_WIDTH-1:0] reactive_power,
	input  wire logic                          power_valid,
	input  wire logic                          energy_pulse_output,
	input  wire logic                          energy_pulse_negative,
	input  wire logic                          reactive_pulse_output,
	input  wire logic                          reactive_pulse_negative,
	input  wire logic                          fault_mode,
	input  wire logic                          tamper_prefers_b,
	output logic signed [POWER_WIDTH-1:0]      active_contrib,
	output logic signed [POWER_WIDTH-1:0]      reactive_contrib,
	output logic                               contrib_valid,
	output logic [2:0]                         voltage_gain_shift,
	output logic [2:0]                         current_gain_shift,
	output logic                               current_uses_b,
	output logic                               voltage_input_ground,
	output logic                               current_input_ground,
	output logic [1:0]                         noload_threshold_sel,
	output logic                               irq
);

	reg_byte_t                      accum_mode;
	reg_byte_t                      gain_cfg;
	reg_byte_t                      cal_sel;
	reg_byte_t                      noload_sel;
	reg_byte_t                      irq_status;
	reg_byte_t                      irq_enable;
	logic [6:0]                     accum_cfg;
	logic                           active_neg_prev;
	logic                           reactive_neg_prev;
	logic                           fault_prev;
	logic                           setup_ok;
	logic                           access_done;
	logic                           wr_byte0;
	logic [9:0]                     reg_index;
	logic                           mapped;
	reg_byte_t                      next_rdata;
	logic                           active_event;
	logic                           reactive_event;
	logic                           active_neg_now;
	logic                           reactive_neg_now;
	logic                           active_change;
	logic                           reactive_change;
	logic                           fault_change;
	reg_byte_t                      event_bits;
	sign_point_e                    sign_point;
	chan_sel_e                      chan_choice;
	logic signed [POWER_WIDTH-1:0]  next_active;
	logic signed [POWER_WIDTH-1:0]  next_reactive;

	// gain code to shift count; codes above 100 are clamped to gain 16
	function automatic logic [2:0] gain_shift(input logic [2:0] code);
		if (code > `GAIN_MAX_SHIFT)
		begin
			return `GAIN_MAX_SHIFT;
		end
		return code;
	endfunction

	// apb decode; access phase is two cycles, pready registered
	assign reg_index   = paddr[11:2];
	assign setup_ok    = psel && penable && !pready;
	assign access_done = psel && penable && pready;
	assign wr_byte0    = access_done && pwrite && pstrb[0];

	// index decode, shared by read mux and error flag
	always_comb
	begin
		mapped     = 1'b1;
		next_rdata = `RESET_BYTE;
		unique case (reg_index)
			`IDX_ACC_MODE: next_rdata = accum_mode;
			`IDX_GAIN:     next_rdata = gain_cfg;
			`IDX_CAL_SEL:  next_rdata = cal_sel;
			`IDX_NOLOAD:   next_rdata = noload_sel;
			`IDX_IRQ_STAT: next_rdata = irq_status;
			`IDX_IRQ_EN:   next_rdata = irq_enable;
			`IDX_IRQ_CLR:  next_rdata = `RESET_BYTE;
			default:       mapped     = 1'b0;
		endcase
	end

	// bus answer: ready one cycle into the access phase
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			pready  <= 1'b0;
			prdata  <= 32'h0000_0000;
			pslverr <= 1'b0;
		end
		else
		begin
			pready <= setup_ok;
			if (setup_ok)
			begin
				prdata  <= pwrite ? 32'h0000_0000 : {24'h00_0000, next_rdata};
				pslverr <= !mapped;
			end
			else
			begin
				pslverr <= 1'b0;
			end
		end
	end

	// accumulation mode, read-only channel bit kept apart
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			accum_cfg <= 7'h00;
		end
		else if (wr_byte0 && reg_index == `IDX_ACC_MODE)
		begin
			accum_cfg <= 7'(pwdata[7:0] & `ACC_WR_MASK);
		end
	end

	// [R1] tamper channel report; one driver for the whole byte
	assign accum_mode = {current_uses_b, accum_cfg};

	// gain register; reserved bit 4 never stored
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			gain_cfg <= `RESET_BYTE;
		end
		else if (wr_byte0 && reg_index == `IDX_GAIN)
		begin
			// [R18] reserved gain bit dropped
			gain_cfg <= pwdata[7:0] & `GAIN_WR_MASK;
		end
	end

	// calibration select; bits 7-6 and 1-0 not stored
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			cal_sel <= `RESET_BYTE;
		end
		else if (wr_byte0 && reg_index == `IDX_CAL_SEL)
		begin
			// [R18] reserved calibration bits dropped
			cal_sel <= pwdata[7:0] & `CAL_WR_MASK;
		end
	end

	// no-load threshold select, two bits
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			noload_sel <= `RESET_BYTE;
		end
		else if (wr_byte0 && reg_index == `IDX_NOLOAD)
		begin
			noload_sel <= pwdata[7:0] & `NOLOAD_WR_MASK;
		end
	end

	// interrupt enable, same layout as status
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			irq_enable <= `RESET_BYTE;
		end
		else if (wr_byte0 && reg_index == `IDX_IRQ_EN)
		begin
			irq_enable <= pwdata[7:0] & `IRQ_MASK;
		end
	end

	// configuration outputs, all registered
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			voltage_gain_shift   <= 3'h0;
			current_gain_shift   <= 3'h0;
			voltage_input_ground <= 1'b0;
			current_input_ground <= 1'b0;
			noload_threshold_sel <= 2'h0;
		end
		else
		begin
			// [R9] voltage gain decode
			voltage_gain_shift   <= gain_shift(gain_cfg[`GAIN_V_HI:`GAIN_V_LO]);
			// [R10] current gain decode
			current_gain_shift   <= gain_shift(gain_cfg[`GAIN_I_HI:`GAIN_I_LO]);
			// [R13] voltage input grounding
			voltage_input_ground <= cal_sel[`CAL_V_GND];
			// [R14] current input grounding
			current_input_ground <= cal_sel[`CAL_I_GND];
			// [R16] threshold code, 00 disables
			noload_threshold_sel <= noload_sel[1:0];
		end
	end

	// channel choice; auto codes follow the tamper logic
	assign chan_choice = chan_sel_e'(cal_sel[`CAL_SEL_HI:`CAL_SEL_LO]);

	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			current_uses_b <= 1'b0;
		end
		else
		begin
			// [R12] forced or automatic input
			unique case (chan_choice)
				CHAN_FORCE_A:               current_uses_b <= 1'b0;
				CHAN_FORCE_B:               current_uses_b <= 1'b1;
				CHAN_AUTO_LO, CHAN_AUTO_HI: current_uses_b <= tamper_prefers_b;
			endcase
		end
	end

	// active term; absolute wins over positive-only if both set
	always_comb
	begin
		next_active = active_power;
		// [R8] absolute active value
		if (accum_mode[`ACC_A_ABS])
		begin
			next_active = active_power[POWER_WIDTH-1] ? -active_power : active_power;
		end
		// [R7] drop negative active power
		else if (accum_mode[`ACC_A_POS] && active_power[POWER_WIDTH-1])
		begin
			next_active = '0;
		end
	end

	// reactive term; absolute wins over signed-by-active
	always_comb
	begin
		next_reactive = reactive_power;
		// [R5] absolute reactive value
		if (accum_mode[`ACC_R_ABS])
		begin
			next_reactive = reactive_power[POWER_WIDTH-1] ? -reactive_power
				: reactive_power;
		end
		// [R6] reactive sign follows active
		else if (accum_mode[`ACC_R_BY_ACT] && active_power[POWER_WIDTH-1])
		begin
			next_reactive = -reactive_power;
		end
	end

	// one shaped term per sample, feeding register and pulse path alike
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			active_contrib   <= '0;
			reactive_contrib <= '0;
			contrib_valid    <= 1'b0;
		end
		else
		begin
			contrib_valid <= power_valid;
			if (power_valid)
			begin
				active_contrib   <= next_active;
				reactive_contrib <= next_reactive;
			end
		end
	end

	// [R11] sign detect point select
	assign sign_point = sign_point_e'(gain_cfg[`GAIN_SIGN_PT]);

	// sign source: filtered samples or per output pulse
	always_comb
	begin
		if (sign_point == SIGN_PER_PULSE)
		begin
			active_event     = energy_pulse_output;
			active_neg_now   = energy_pulse_negative;
			reactive_event   = reactive_pulse_output;
			reactive_neg_now = reactive_pulse_negative;
		end
		else
		begin
			active_event     = power_valid;
			active_neg_now   = active_power[POWER_WIDTH-1];
			reactive_event   = power_valid;
			reactive_neg_now = reactive_power[POWER_WIDTH-1];
		end
	end

	// remembered signs; first sample after reset counts from positive
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			active_neg_prev   <= 1'b0;
			reactive_neg_prev <= 1'b0;
			fault_prev        <= 1'b0;
		end
		else
		begin
			fault_prev <= fault_mode;
			if (active_event)
			begin
				active_neg_prev <= active_neg_now;
			end
			if (reactive_event)
			begin
				reactive_neg_prev <= reactive_neg_now;
			end
		end
	end

	// [R4] active edge selection
	assign active_change = active_event && (active_neg_now != active_neg_prev)
		&& (active_neg_now != accum_mode[`ACC_ASIGN_EDGE]);

	// [R3] reactive edge selection
	assign reactive_change = reactive_event && (reactive_neg_now != reactive_neg_prev)
		&& (reactive_neg_now != accum_mode[`ACC_RSIGN_EDGE]);

	// [R2] fault entry or return
	assign fault_change = (fault_mode != fault_prev)
		&& (fault_mode != accum_mode[`ACC_FAULT_EDGE]);

	// event vector in status layout
	always_comb
	begin
		event_bits = `RESET_BYTE;
		// [R17] active sign sets bit 3
		event_bits[`IRQ_ASIGN] = active_change;
		event_bits[`IRQ_RSIGN] = reactive_change;
		event_bits[`IRQ_FAULT] = fault_change;
	end

	// sticky status; a new event beats a clear in the same cycle
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			irq_status <= `RESET_BYTE;
		end
		else if (wr_byte0 && reg_index == `IDX_IRQ_CLR)
		begin
			irq_status <= ((irq_status & ~pwdata[7:0]) | event_bits) & `IRQ_MASK;
		end
		else
		begin
			irq_status <= (irq_status | event_bits) & `IRQ_MASK;
		end
	end

	// level interrupt, one cycle behind status
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			irq <= 1'b0;
		end
		else
		begin
			irq <= |(irq_status & irq_enable);
		end
	end

endmodule

// ===== hdl/energy_accum_pkg.sv
package energy_accum_pkg;

	typedef logic [7:0] reg_byte_t;

	// where the sign interrupts look at power
	typedef enum logic
	{
		SIGN_FILTERED,
		SIGN_PER_PULSE
	} sign_point_e;

	// current input choice as stored in the select field
	typedef enum logic [1:0]
	{
		CHAN_AUTO_LO,
		CHAN_FORCE_A,
		CHAN_FORCE_B,
		CHAN_AUTO_HI
	} chan_sel_e;

endpackage
